// ### logic/rfes_frame_track.sv
// Frame length counter, truncation and broadcast detection
`timescale 1ns/1ps
module rfes_frame_track
    import rfes_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Stream and status
    rfes_frm_if.trk   frm
);

    rfes_state_t           state_r, state_nxt;
    logic [RFES_CNT_W-1:0] cnt_r, cnt_nxt;
    logic                  bc_r, bc_nxt;
    logic                  sv_r, sv_nxt;
    logic [7:0]            sd_r, sd_nxt;

    // ------------------------------------------------------------------
    // Next state: count bytes, saturating so huge frames stay oversize
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        bc_nxt    = bc_r;
        sv_nxt    = 1'b0;
        sd_nxt    = sd_r;
        case (state_r)
            RFES_IDLE: begin
                if (frm.sof) begin
                    state_nxt = RFES_RECV;
                    cnt_nxt   = '0;
                    bc_nxt    = 1'b1;
                end
            end
            RFES_RECV: begin
                if (frm.eof) begin
                    state_nxt = RFES_IDLE;
                end else if (frm.bvalid) begin
                    if (cnt_r != '1)
                        cnt_nxt = cnt_r + 1'b1;
                    // Any clear bit in the six address bytes
                    if (cnt_r < RFES_DA_LEN && frm.bdata != RFES_BC_BYTE)
                        bc_nxt = 1'b0;
                    // Bytes past the length limit are never stored
                    if (cnt_r < RFES_MAX_LEN) begin
                        sv_nxt = 1'b1;
                        sd_nxt = frm.bdata;
                    end
                end
            end
            default: state_nxt = RFES_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= RFES_IDLE;
            cnt_r   <= '0;
            bc_r    <= 1'b0;
            sv_r    <= 1'b0;
            sd_r    <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            bc_r    <= bc_nxt;
            sv_r    <= sv_nxt;
            sd_r    <= sd_nxt;
        end
    end

    // Status seen by the top at end of frame
    assign frm.oversize    = (cnt_r > RFES_MAX_LEN);
    assign frm.short_frm   = (cnt_r < RFES_MIN_LEN);
    assign frm.bcast       = bc_r && (cnt_r >= RFES_DA_LEN);
    assign frm.store_valid = sv_r;
    assign frm.store_data  = sd_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    store_limit_a: assert property (@(posedge sys_clk)
        disable iff (rst)
        (state_r == RFES_RECV && frm.bvalid && !frm.eof
         && cnt_r >= RFES_MAX_LEN) |=> !sv_r)
        else $error("Byte beyond length limit was stored");

endmodule

// ### logic/rfes_frm_if.sv
// Byte stream and length status between top and frame tracker
`timescale 1ns/1ps
interface rfes_frm_if;
    logic       sof;
    logic       eof;
    logic       bvalid;
    logic [7:0] bdata;
    logic       oversize;
    logic       short_frm;
    logic       bcast;
    logic       store_valid;
    logic [7:0] store_data;

    modport top  (output sof, eof, bvalid, bdata,
                  input  oversize, short_frm, bcast, store_valid,
                         store_data);
    modport trk  (input  sof, eof, bvalid, bdata,
                  output oversize, short_frm, bcast, store_valid,
                         store_data);
endinterface

// ### logic/rfes_pkg.sv
// Constants for the receive frame event status block
package rfes_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] RFES_EVT_ADDR  = 12'h124;
    localparam logic [11:0] RFES_MIR_ADDR  = 12'h400;
    localparam logic [11:0] RFES_CFG_ADDR  = 12'h108;
    localparam logic [11:0] RFES_IST_ADDR  = 12'h10c;
    localparam logic [11:0] RFES_IMSK_ADDR = 12'h110;

    // ------------------------------------------------------------------
    // Reset values and identifying codes
    // ------------------------------------------------------------------
    localparam logic [15:0] RFES_EVT_RST = 16'h0004;
    localparam logic [5:0]  RFES_EVT_ID  = 6'h04;
    localparam logic [5:0]  RFES_CFG_ID  = 6'h03;
    localparam logic [15:0] RFES_CFG_RST = 16'h0003;

    // ------------------------------------------------------------------
    // Event word bit positions
    // ------------------------------------------------------------------
    localparam int RFES_EV_DRIB  = 7;
    localparam int RFES_EV_IAH   = 6;
    localparam int RFES_EV_GOOD  = 8;
    localparam int RFES_EV_HASH  = 9;
    localparam int RFES_EV_STA   = 10;
    localparam int RFES_EV_BC    = 11;
    localparam int RFES_EV_CRC   = 12;
    localparam int RFES_EV_SHORT = 13;
    localparam int RFES_EV_OVER  = 14;
    localparam int RFES_EV_HIDX  = 10;

    // ------------------------------------------------------------------
    // Receive configuration bits
    // ------------------------------------------------------------------
    localparam int RFES_CF_GOOD_IE  = 8;
    localparam int RFES_CF_DMA_EXCL = 9;
    localparam int RFES_CF_CRC_IE   = 12;
    localparam int RFES_CF_SHORT_IE = 13;
    localparam int RFES_CF_OVER_IE  = 14;

    // ------------------------------------------------------------------
    // Interrupt status / mask bits
    // ------------------------------------------------------------------
    localparam int RFES_IW    = 4;
    localparam int RFES_IS_GD = 0;
    localparam int RFES_IS_CR = 1;
    localparam int RFES_IS_SH = 2;
    localparam int RFES_IS_OV = 3;

    // ------------------------------------------------------------------
    // Frame lengths and address width
    // ------------------------------------------------------------------
    localparam int RFES_CNT_W   = 11;
    localparam logic [10:0] RFES_MAX_LEN = 11'd1518;
    localparam logic [10:0] RFES_MIN_LEN = 11'd64;
    localparam logic [10:0] RFES_DA_LEN  = 11'd6;
    localparam logic [7:0]  RFES_BC_BYTE = 8'hff;

    // Frame tracker states, Gray ordered
    typedef enum logic [1:0] {
        RFES_IDLE = 2'b00,
        RFES_RECV = 2'b01
    } rfes_state_t;

endpackage

// ### logic/rfes_top.sv
// Receive frame event status block with APB register access
// Notes on behaviour
// - Event register read-only at 0x124; host writes leave it unchanged.
// - Event register resets to 0x0004, flags clear, identifier in low bits.
// - Reading the event register returns flags, then clears every flag.
// - Mirror register at 0x400 holds same content for current frame.
// - Event register reads leave the mirror register untouched.
// - Event content undefined while DMA-exclusive bit 9 is set.
// - Oversize flag set when frame exceeds 1518 bytes.
// - Bytes past byte 1518 are dropped, never stored.
// - Oversize flag with oversize enable (bit E) raises an interrupt.
// - Frames under 64 bytes set short flag; enable raises interrupt.
// - Bad CRC sets CRC flag; enable raises interrupt.
// - Good frame interrupts when enabled, except in DMA reception mode.
// - Broadcast flag only when destination is all ones, 48 bits.
`timescale 1ns/1ps
module rfes_top
    import rfes_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    // Clock and reset
    sys_clk,
    rst,
    // APB slave
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    // Receive stream from the MAC
    rx_sof,
    rx_eof,
    rx_valid,
    rx_data,
    rx_crc_bad,
    rx_extra_bits,
    rx_hash_hit,
    rx_ia_hash,
    rx_hash_index,
    rx_station_match,
    // Frame data towards storage
    store_valid,
    store_data,
    // Interrupt
    irq
);
    input  wire logic              sys_clk;
    input  wire logic              rst;
    input  wire logic              psel;
    input  wire logic              penable;
    input  wire logic              pwrite;
    input  wire logic [ADDR_W-1:0] paddr;
    input  wire logic [31:0]       pwdata;
    output logic      [31:0]       prdata;
    output logic                   pready;
    output logic                   pslverr;
    input  wire logic              rx_sof;
    input  wire logic              rx_eof;
    input  wire logic              rx_valid;
    input  wire logic [7:0]        rx_data;
    input  wire logic              rx_crc_bad;
    input  wire logic [2:0]        rx_extra_bits;
    input  wire logic              rx_hash_hit;
    input  wire logic              rx_ia_hash;
    input  wire logic [5:0]        rx_hash_index;
    input  wire logic              rx_station_match;
    output logic                   store_valid;
    output logic      [7:0]        store_data;
    output logic                   irq;

    // ------------------------------------------------------------------
    // Frame tracker
    // ------------------------------------------------------------------
    rfes_frm_if frm ();

    assign frm.sof    = rx_sof;
    assign frm.eof    = rx_eof;
    assign frm.bvalid = rx_valid;
    assign frm.bdata  = rx_data;

    rfes_frame_track u_trk (
        .sys_clk (sys_clk),
        .rst     (rst),
        .frm     (frm)
    );

    assign store_valid = frm.store_valid;
    assign store_data  = frm.store_data;

    // ------------------------------------------------------------------
    // Event word of the frame that ends this cycle
    // ------------------------------------------------------------------
    logic [15:0] ev_word;
    logic        ev_good;

    assign ev_good = !rx_crc_bad && !frm.short_frm && !frm.oversize;

    always_comb begin
        ev_word                = {10'h000, RFES_EVT_ID};
        ev_word[RFES_EV_DRIB]  = (rx_extra_bits != 3'h0);
        ev_word[RFES_EV_IAH]   = rx_ia_hash;
        ev_word[RFES_EV_GOOD]  = ev_good;
        ev_word[RFES_EV_HASH]  = rx_hash_hit;
        ev_word[RFES_EV_STA]   = rx_station_match;
        ev_word[RFES_EV_BC]    = frm.bcast;
        ev_word[RFES_EV_CRC]   = rx_crc_bad;
        ev_word[RFES_EV_SHORT] = frm.short_frm;
        ev_word[RFES_EV_OVER]  = frm.oversize;
        // Error and class bits carry the hash index for good hashed frames
        if (ev_good && rx_hash_hit)
            ev_word[15:RFES_EV_HIDX] = rx_hash_index;
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic apb_setup;
    logic apb_acc;
    logic wr_acc;
    logic rd_acc;
    logic hit_evt;
    logic hit_cfg;
    logic hit_ist;
    logic hit_imsk;
    logic hit_mir;
    logic hit_any;

    assign apb_setup = psel && !penable;
    assign apb_acc   = psel && penable;
    assign wr_acc    = apb_acc && pwrite;
    assign rd_acc    = apb_acc && !pwrite;
    assign hit_evt   = (paddr == ADDR_W'(RFES_EVT_ADDR));
    assign hit_mir   = (paddr == ADDR_W'(RFES_MIR_ADDR));
    assign hit_cfg   = (paddr == ADDR_W'(RFES_CFG_ADDR));
    assign hit_ist   = (paddr == ADDR_W'(RFES_IST_ADDR));
    assign hit_imsk  = (paddr == ADDR_W'(RFES_IMSK_ADDR));
    assign hit_any   = hit_evt | hit_mir | hit_cfg | hit_ist | hit_imsk;

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = apb_acc && !hit_any;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [15:0]        evt_r, evt_nxt;
    logic [15:0]        mir_r, mir_nxt;
    logic [15:0]        cfg_r, cfg_nxt;
    logic [RFES_IW-1:0] ist_r, ist_nxt;
    logic [RFES_IW-1:0] imsk_r, imsk_nxt;
    logic [31:0]        rd_r, rd_nxt;
    logic               stale_r, stale_nxt;
    logic [RFES_IW-1:0] ist_set;

    // Interrupt causes, each gated by its enable
    always_comb begin
        ist_set = '0;
        if (rx_eof) begin
            ist_set[RFES_IS_GD] = ev_good && cfg_r[RFES_CF_GOOD_IE]
                                  && !cfg_r[RFES_CF_DMA_EXCL];
            ist_set[RFES_IS_CR] = rx_crc_bad
                                  && cfg_r[RFES_CF_CRC_IE];
            ist_set[RFES_IS_SH] = frm.short_frm
                                  && cfg_r[RFES_CF_SHORT_IE];
            ist_set[RFES_IS_OV] = frm.oversize
                                  && cfg_r[RFES_CF_OVER_IE];
        end
    end

    // Next values of all registers
    always_comb begin
        evt_nxt   = evt_r;
        mir_nxt   = mir_r;
        cfg_nxt   = cfg_r;
        imsk_nxt  = imsk_r;
        rd_nxt    = rd_r;
        stale_nxt = stale_r;
        // A frame landing in the setup cycle makes the captured read old
        if (apb_setup) begin
            stale_nxt = rx_eof;
            rd_nxt    = 32'h0000_0000;
            if (hit_evt)  rd_nxt = {16'h0000, evt_r};
            if (hit_mir)  rd_nxt = {16'h0000, mir_r};
            if (hit_cfg)  rd_nxt = {16'h0000, cfg_r};
            if (hit_ist)  rd_nxt = {28'h0000000, ist_r};
            if (hit_imsk) rd_nxt = {28'h0000000, imsk_r};
        end
        // Clear only what was returned; a new frame wins over the clear
        if (rd_acc && hit_evt && !stale_r)
            evt_nxt = RFES_EVT_RST;
        if (rx_eof) begin
            evt_nxt = ev_word;
            mir_nxt = ev_word;
        end
        // Event and mirror ignore writes; low identifier bits are fixed
        if (wr_acc && hit_cfg)
            cfg_nxt = {pwdata[15:6], RFES_CFG_ID};
        if (wr_acc && hit_imsk)
            imsk_nxt = pwdata[RFES_IW-1:0];
        // Sticky status: write one clears, new events win
        ist_nxt = ist_r;
        if (wr_acc && hit_ist)
            ist_nxt = ist_r & ~pwdata[RFES_IW-1:0];
        ist_nxt = ist_nxt | ist_set;
    end

    // Register update
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evt_r   <= RFES_EVT_RST;
            mir_r   <= RFES_EVT_RST;
            cfg_r   <= RFES_CFG_RST;
            ist_r   <= '0;
            imsk_r  <= '0;
            rd_r    <= 32'h0000_0000;
            stale_r <= 1'b0;
        end else begin
            evt_r   <= evt_nxt;
            mir_r   <= mir_nxt;
            cfg_r   <= cfg_nxt;
            ist_r   <= ist_nxt;
            imsk_r  <= imsk_nxt;
            rd_r    <= rd_nxt;
            stale_r <= stale_nxt;
        end
    end

    // In DMA-exclusive mode the event word is still written but meaningless
    assign prdata = rd_r;
    assign irq    = |(ist_r & imsk_r);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    evt_ro_a: assert property ((wr_acc && hit_evt && !rx_eof)
        |=> evt_r == $past(evt_r))
        else $error("Event register changed on a host write");
    evt_reset_a: assert property ($past(rst)
        |-> evt_r == RFES_EVT_RST)
        else $error("Event register reset value wrong");
    read_clear_a: assert property ((rd_acc && hit_evt && !stale_r
        && !rx_eof) |=> evt_r == RFES_EVT_RST)
        else $error("Event register not cleared by read");
    mirror_keep_a: assert property ((rd_acc && hit_evt && !rx_eof)
        |=> mir_r == $past(mir_r))
        else $error("Mirror changed by event read");
    mirror_same_a: assert property (rx_eof |=> mir_r == evt_r)
        else $error("Mirror differs from event word");
    over_flag_a: assert property (rx_eof && frm.oversize
        |=> evt_r[RFES_EV_OVER])
        else $error("Oversize flag missing");
    // The host may clear status right after the frame, so one cycle only
    over_irq_a: assert property ((rx_eof && frm.oversize
        && cfg_r[RFES_CF_OVER_IE] && imsk_r[RFES_IS_OV])
        |=> ist_r[RFES_IS_OV] && irq)
        else $error("Oversize interrupt not raised");
    short_ist_a: assert property ((rx_eof && frm.short_frm
        && cfg_r[RFES_CF_SHORT_IE]) |=> ist_r[RFES_IS_SH])
        else $error("Short frame status missing");
    short_flag_a: assert property (rx_eof && frm.short_frm
        |=> evt_r[RFES_EV_SHORT])
        else $error("Short frame flag missing");
    crc_ist_a: assert property ((rx_eof && rx_crc_bad
        && cfg_r[RFES_CF_CRC_IE]) |=> ist_r[RFES_IS_CR])
        else $error("CRC failure status missing");
    crc_flag_a: assert property (rx_eof && rx_crc_bad
        |=> evt_r[RFES_EV_CRC])
        else $error("CRC failure flag missing");
    good_ist_a: assert property ((rx_eof && ev_good
        && cfg_r[RFES_CF_GOOD_IE] && !cfg_r[RFES_CF_DMA_EXCL])
        |=> ist_r[RFES_IS_GD])
        else $error("Good frame status missing");
    good_dma_a: assert property ((rx_eof && cfg_r[RFES_CF_DMA_EXCL]
        && !ist_r[RFES_IS_GD]) |=> !ist_r[RFES_IS_GD])
        else $error("Good frame interrupt in DMA mode");
    hash_idx_a: assert property ((rx_eof && ev_good && rx_hash_hit)
        |=> evt_r[15:RFES_EV_HIDX] == $past(rx_hash_index))
        else $error("Hash index not reported");
    extra_bit_a: assert property ((rx_eof && rx_extra_bits != 3'h0)
        |=> evt_r[RFES_EV_DRIB])
        else $error("Extra bit flag missing");

    good_frame_c: cover property (rx_eof && ev_good
        ##[1:40] rd_acc && hit_evt);
    read_race_c:  cover property (rd_acc && hit_evt && rx_eof);
    over_frame_c: cover property (rx_eof && frm.oversize);
    dma_frame_c:  cover property (rx_eof && cfg_r[RFES_CF_DMA_EXCL]);
    hash_idx_c:   cover property (rx_eof && ev_good && rx_hash_hit);

endmodule

// ### verification/rfes_host_model.sv
// APB host model that carries out register transfers for the bench
`timescale 1ns/1ps
module rfes_host_model (
    // Clock
    input  wire logic        sys_clk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    // Setup, then access held until pready; a stall of 32 access cycles is a timeout
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err, output logic tmo);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 32);
        tmo = (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        // Released address and data lines show a changed pattern, never the old value; pwrite keeps its value
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~wd;
    endtask
endmodule

// ### verification/rx_frame_event_status_tb.sv
// Self-checking bench for the receive frame event status block
`timescale 1ns/1ps
module rx_frame_event_status_tb
    import rfes_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals, counters and stimulus state
    // ------------------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, irq, store_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        rx_sof = 0, rx_eof = 0, rx_valid = 0, rx_crc_bad = 0;
    logic        rx_hash_hit = 0, rx_ia_hash = 0, rx_station_match = 0;
    logic [7:0]  rx_data = 8'h00, store_data;
    logic [2:0]  rx_extra_bits = 3'h0;
    logic [5:0]  rx_hash_index = 6'h00;
    logic [7:0]  sent [0:1517];
    int          n_errors = 0, num_checks = 0, n_stored = 0;
    integer      seed = 32'h3fa5;

    // 50 MHz clock
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    rfes_top #(.ADDR_W(12)) dut (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_sof(rx_sof),
        .rx_eof(rx_eof), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_crc_bad(rx_crc_bad), .rx_extra_bits(rx_extra_bits),
        .rx_hash_hit(rx_hash_hit), .rx_ia_hash(rx_ia_hash),
        .rx_hash_index(rx_hash_index), .rx_station_match(rx_station_match),
        .store_valid(store_valid), .store_data(store_data), .irq(irq));

    rfes_host_model host (
        .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ------------------------------------------------------------------
    // Shared tasks and expectations
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // One register transfer; err is returned for the caller to judge
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        logic tmo;
        host.xfer(wr, a, wd, rd, err, tmo);
        if (tmo) chk(32'h1, 32'h0, "bus timeout");
    endtask

    function automatic logic [15:0] exp_evt(int len, logic bc, logic crc,
        logic [2:0] ext, logic hh, logic ia, logic [5:0] hi, logic st);
        logic [15:0] w;
        w = RFES_EVT_RST;
        w[RFES_EV_DRIB]  = (ext != 3'd0);
        w[RFES_EV_IAH]   = ia;
        w[RFES_EV_GOOD]  = !crc && len >= 64 && len <= 1518;
        w[RFES_EV_HASH]  = hh;
        w[RFES_EV_STA]   = st;
        w[RFES_EV_BC]    = bc;
        w[RFES_EV_CRC]   = crc;
        w[RFES_EV_SHORT] = len < 64;
        w[RFES_EV_OVER]  = len > 1518;
        // Hash index overlays the class flags of a good hashed frame
        if (w[RFES_EV_GOOD] && hh) w[15:10] = hi;
        return w;
    endfunction

    // Flags come from the raw outcome: the overlay hides them
    function automatic logic [31:0] exp_ist(int len, logic crc,
                                            logic [31:0] cf);
        logic [31:0] s;
        s = 32'h0;
        s[RFES_IS_GD] = !crc && len >= 64 && len <= 1518 &&
                        cf[RFES_CF_GOOD_IE] && !cf[RFES_CF_DMA_EXCL];
        s[RFES_IS_CR] = crc && cf[RFES_CF_CRC_IE];
        s[RFES_IS_SH] = len < 64 && cf[RFES_CF_SHORT_IE];
        s[RFES_IS_OV] = len > 1518 && cf[RFES_CF_OVER_IE];
        return s;
    endfunction

    // Frame: sof, bytes, eof with side info; bcm 1 all ones, 2 near miss
    task automatic send_frame(int len, int bcm, logic crc, logic [2:0] ext,
                              logic hh, logic ia, logic [5:0] hi, logic st);
        logic [7:0] b;
        n_stored = 0;
        @(posedge sys_clk);
        rx_sof <= 1'b1;
        @(posedge sys_clk);
        rx_sof <= 1'b0;
        for (int i = 0; i < len; i++) begin
            b = 8'($random(seed));
            if (i < 6) b = (bcm == 0) ? 8'h00 : 8'hff;
            if (i == 5 && bcm == 2) b = 8'hfe;
            if (i < 1518) sent[i] = b;
            rx_valid <= 1'b1;
            rx_data  <= b;
            @(posedge sys_clk);
        end
        rx_valid         <= 1'b0;
        rx_eof           <= 1'b1;
        rx_crc_bad       <= crc;
        rx_extra_bits    <= ext;
        rx_hash_hit      <= hh;
        rx_ia_hash       <= ia;
        rx_hash_index    <= hi;
        rx_station_match <= st;
        @(posedge sys_clk);
        rx_eof <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Every stored byte must be the next byte sent, in order
    always @(posedge sys_clk) begin
        if (store_valid === 1'b1) begin
            if (n_stored < 1518)
                chk(32'(store_data), 32'(sent[n_stored]), "store");
            n_stored = n_stored + 1;
        end
    end

    // Cuts a hang short after about 20000 cycles
    initial begin
        #400000;
        chk(32'h1, 32'h0, "watchdog");
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int          lens [8] = '{63, 64, 1518, 1519, 1521, 5, 65, 6};
        int          len, bcm;
        logic [31:0] r, cf, msk, d, ex;
        logic        err;
        logic [15:0] ev;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        bus(0, RFES_EVT_ADDR, 0, d, err);
        chk(d, 32'h0004, "evt rst");
        bus(0, RFES_MIR_ADDR, 0, d, err);
        chk(d, 32'h0004, "mir rst");
        bus(0, RFES_CFG_ADDR, 0, d, err);
        chk(d, 32'h0003, "cfg rst");
        bus(0, RFES_IMSK_ADDR, 0, d, err);
        chk(d, 32'h0, "mask rst");
        // Writes to the event register are ignored without error
        bus(1, RFES_EVT_ADDR, 32'hffff, d, err);
        chk({31'h0, err}, 0, "we");
        bus(0, RFES_EVT_ADDR, 0, d, err);
        chk(d, 32'h0004, "evt ro");
        bus(0, 12'h200, 0, d, err);
        chk({31'h0, err}, 32'h1, "unmapped");
        for (int f = 0; f < 16; f++) begin
            r   = $random(seed);
            len = (f < 8) ? lens[f] : 6 + ($unsigned($random(seed)) % 200);
            bcm = (len < 6) ? 0 : f % 3;
            cf  = 32'h0003;
            cf[RFES_CF_GOOD_IE]  = r[0] | (f < 8);
            cf[RFES_CF_DMA_EXCL] = (r[2:1] == 2'b00) && f >= 8;
            cf[RFES_CF_CRC_IE]   = r[3] | (f < 8);
            cf[RFES_CF_SHORT_IE] = r[4] | (f < 8);
            cf[RFES_CF_OVER_IE]  = r[5] | (f < 8);
            msk = {28'h0, r[9:6] | {4{f < 4}}};
            bus(1, RFES_CFG_ADDR, cf, d, err);
            bus(1, RFES_IMSK_ADDR, msk, d, err);
            ev = exp_evt(len, bcm == 1, r[10], r[13:11], r[14], r[15],
                         r[21:16], r[22]);
            send_frame(len, bcm, r[10], r[13:11], r[14], r[15], r[21:16],
                       r[22]);
            chk(n_stored, (len > 1518) ? 1518 : len, "stored count");
            bus(0, RFES_MIR_ADDR, 0, d, err);
            chk(d, {16'h0, ev}, "mir");
            ex = exp_ist(len, r[10], cf);
            bus(0, RFES_IST_ADDR, 0, d, err);
            chk(d, ex, "ist");
            chk(32'(irq), 32'(|(ex & msk)), "irq");
            // The host acts on the flags of one read; event content is
            // not relied upon in DMA-exclusive mode
            bus(0, RFES_EVT_ADDR, 0, d, err);
            if (!cf[RFES_CF_DMA_EXCL])
                chk(d, {16'h0, ev}, "evt");
            bus(0, RFES_EVT_ADDR, 0, d, err);
            chk(d, 32'h0004, "evt clr");
            bus(0, RFES_MIR_ADDR, 0, d, err);
            chk(d, {16'h0, ev}, "mir kept");
            bus(1, RFES_IST_ADDR, 32'hf, d, err);
            bus(0, RFES_IST_ADDR, 0, d, err);
            chk(d, 32'h0, "ist w1c");
            chk(32'(irq), 32'h0, "irq clear");
        end
        final_report();
    end
endmodule
